// File: radio_regs_pkg.sv
// shared constants and carrier types for the radio calibration and status register bank
package radio_regs_pkg;

   // ---------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [15:0] IDX_COARSE_TUNE_CAL         = 16'hDF1E;
   localparam logic [15:0] IDX_SYNTH_CAL_CONTROL       = 16'hDF1F;
   localparam logic [15:0] IDX_TEST_SETTING_C          = 16'hDF23;
   localparam logic [15:0] IDX_TEST_SETTING_B          = 16'hDF24;
   localparam logic [15:0] IDX_TEST_SETTING_A          = 16'hDF25;
   localparam logic [15:0] IDX_AMP_POWER_LEVEL         = 16'hDF2E;
   localparam logic [15:0] IDX_CHIP_ID_HIGH            = 16'hDF36;
   localparam logic [15:0] IDX_CHIP_ID_LOW             = 16'hDF37;
   localparam logic [15:0] IDX_CARRIER_OFFSET_ESTIMATE = 16'hDF38;
   localparam logic [15:0] IDX_LINK_QUALITY_STATUS     = 16'hDF39;

   // ---------------------------------------------------------------
   // reset values and field layout
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_COARSE_TUNE_CAL   = 8'h20;
   localparam logic [7:0] RST_SYNTH_CAL_CONTROL = 8'h0D;
   localparam logic [7:0] RST_TEST_SETTING_C    = 8'h88;
   localparam logic [7:0] RST_TEST_SETTING_B    = 8'h11;
   localparam logic [7:0] RST_TEST_SETTING_A    = 8'h0B;
   localparam logic [7:0] RST_AMP_POWER_LEVEL   = 8'h00;
   localparam logic [7:0] RST_OFFSET_ESTIMATE   = 8'h00;
   localparam logic [6:0] RST_LINK_QUALITY      = 7'h00;
   localparam logic [7:0] MASK_COARSE_TUNE      = 8'h3F;
   localparam logic [7:0] MASK_SYNTH_CAL        = 8'h7F;
   localparam int         OSC_SELECT_CAL_BIT    = 1;
   localparam int         CRC_MATCH_BIT         = 7;
   localparam int         OFFSET_FRAC_BITS      = 14;
   localparam int         LQI_SYMBOLS           = 64;
   localparam int         LQI_ERR_W             = 4;
   localparam int         WB_ADDR_W             = 18;
   localparam int         WB_DATA_W             = 32;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic [15:0] idx;
      logic [7:0]  wdata;
   } reg_req_t;

   typedef struct packed {
      logic [5:0] coarse_tune_value;
      logic [6:0] synth_cal_control;
      logic [7:0] test_setting_c;
      logic [7:0] test_setting_b;
      logic [7:0] test_setting_a;
      logic [7:0] amp_power_level;
   } radio_config_t;

   typedef struct packed {
      logic       rx_enter;
      logic       crc_done;
      logic       crc_match;
      logic       offset_valid;
      logic [7:0] offset_estimate_value;
   } demod_event_t;

endpackage

// File: radio_wb_slave.sv
// classic wishbone slave front end for the radio register bank
`timescale 1ns/10ps
module radio_wb_slave #(
   parameter int ADDR_W = 18
) (
   input  wire logic                      ref_clk_in,
   input  wire logic                      reset_n_in,
   input  wire logic                      wb_cyc_in,
   input  wire logic                      wb_stb_in,
   input  wire logic                      wb_we_in,
   input  wire logic [ADDR_W-1:0]         wb_adr_in,
   input  wire logic [31:0]               wb_dat_in,
   input  wire logic [3:0]                wb_sel_in,
   output logic      [31:0]               wb_dat_out,
   output logic                           wb_ack_out,
   output radio_regs_pkg::reg_req_t       req_out,
   input  wire logic [7:0]                rdata_in
);

   // refused at elaboration: the index field sits in bits 17:2
   if (ADDR_W < 18) begin
      $error("address too narrow for the register indices");
   end

   logic        ack;
   logic [31:0] dat;
   logic        next_ack;
   logic [31:0] next_dat;
   logic        take;

   // one wait state: request taken while ack is low, answered next cycle
   assign take = wb_cyc_in & wb_stb_in & ~ack;

   always_comb begin
      req_out.wr    = take & wb_we_in & wb_sel_in[0];
      req_out.idx   = wb_adr_in[17:2];
      req_out.wdata = wb_dat_in[7:0];
      next_ack      = take;
      next_dat      = dat;
      if (take) begin
         next_dat = {24'h000000, rdata_in};
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ack <= 1'b0;
         dat <= 32'h00000000;
      end else begin
         ack <= next_ack;
         dat <= next_dat;
      end
   end

   assign wb_ack_out = ack;
   assign wb_dat_out = dat;

endmodule

// File: radio_lqi_estimator.sv
// link quality estimate accumulated over the symbols after sync
`timescale 1ns/10ps
module radio_lqi_estimator #(
   parameter int SYMBOLS = 64,
   parameter int ERR_W   = 4
) (
   input  wire logic             ref_clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             sync_found_in,
   input  wire logic             symbol_valid_in,
   input  wire logic [ERR_W-1:0] symbol_error_in,
   output logic      [6:0]       link_quality_value_out,
   output logic                  estimate_done_out
);

   localparam int CNT_W = $clog2(SYMBOLS);
   localparam int SUM_W = ERR_W + CNT_W;

   // refused at elaboration: the count wraps and the estimate needs seven sum bits
   if (SYMBOLS < 2 || (SYMBOLS & (SYMBOLS - 1)) != 0 || SUM_W < 7) begin
      $error("symbol count must be a power of two and sum at least 7 bits");
   end

   typedef enum logic [0:0] {
      LQI_IDLE    = 1'b0,
      LQI_MEASURE = 1'b1
   } lqi_state_t;

   lqi_state_t       state;
   lqi_state_t       next_state;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic [SUM_W-1:0] sum;
   logic [SUM_W-1:0] next_sum;
   logic [6:0]       lqi;
   logic [6:0]       next_lqi;
   logic             done;
   logic             next_done;

   always_comb begin
      next_state = state;
      next_count = count;
      next_sum   = sum;
      next_lqi   = lqi;
      next_done  = 1'b0;
      case (state)
         LQI_IDLE: begin
            if (sync_found_in) begin
               next_state = LQI_MEASURE;
               next_count = '0;
               next_sum   = '0;
            end
         end
         LQI_MEASURE: begin
            if (sync_found_in) begin
               next_count = '0;
               next_sum   = '0;
            end else if (symbol_valid_in) begin
               next_sum   = sum + SUM_W'(symbol_error_in);
               next_count = count + 1'b1;
               if (count == CNT_W'(SYMBOLS - 1)) begin
                  // higher value means harder to demodulate
                  next_lqi   = next_sum[SUM_W-1 -: 7];
                  next_done  = 1'b1;
                  next_state = LQI_IDLE;
               end
            end
         end
         default: next_state = LQI_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state <= LQI_IDLE;
         count <= '0;
         sum   <= '0;
         lqi   <= 7'h00;
         done  <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         sum   <= next_sum;
         lqi   <= next_lqi;
         done  <= next_done;
      end
   end

   assign link_quality_value_out = lqi;
   assign estimate_done_out      = done;

endmodule

// File: radio_calib_status_regs.sv
// radio calibration, test setting, power and demodulator status register bank
`timescale 1ns/10ps
module radio_calib_status_regs #(
   // arbitrary identification values, not tied to any part
   parameter logic [7:0] PART_ID = 8'h5A,
   parameter logic [7:0] REV_ID  = 8'h01,
   parameter int         SYMBOLS = radio_regs_pkg::LQI_SYMBOLS
) (
   input  wire logic                               ref_clk_in,
   input  wire logic                               reset_n_in,
   // wishbone slave
   input  wire logic                               wb_cyc_in,
   input  wire logic                               wb_stb_in,
   input  wire logic                               wb_we_in,
   input  wire logic [radio_regs_pkg::WB_ADDR_W-1:0] wb_adr_in,
   input  wire logic [radio_regs_pkg::WB_DATA_W-1:0] wb_dat_in,
   input  wire logic [3:0]                         wb_sel_in,
   output logic      [radio_regs_pkg::WB_DATA_W-1:0] wb_dat_out,
   output logic                                    wb_ack_out,
   // power manager
   input  wire logic                               deep_sleep_wake_in,
   // calibration engine
   input  wire logic                               cal_result_valid_in,
   input  wire logic [5:0]                         cal_coarse_tune_in,
   input  wire logic                               osc_select_stage_req_in,
   output logic                                    osc_select_stage_run_out,
   output logic                                    osc_select_cal_enable_out,
   // demodulator and packet engine
   input  wire radio_regs_pkg::demod_event_t       demod_event_in,
   input  wire logic                               crc_check_enable_in,
   input  wire logic                               legacy_packet_compat_enable_in,
   input  wire logic                               sync_found_in,
   input  wire logic                               symbol_valid_in,
   input  wire logic [radio_regs_pkg::LQI_ERR_W-1:0] symbol_error_in,
   output logic                                    crc_match_valid_out,
   // settings to the analog and radio core
   output radio_regs_pkg::radio_config_t           radio_config_out
);

   // ---------------------------------------------------------------
   // bus front end
   // ---------------------------------------------------------------
   radio_regs_pkg::reg_req_t req;
   logic [7:0]               rdata;

   radio_wb_slave #(
      .ADDR_W (radio_regs_pkg::WB_ADDR_W)
   ) u_wb (
      .ref_clk_in (ref_clk_in),
      .reset_n_in (reset_n_in),
      .wb_cyc_in  (wb_cyc_in),
      .wb_stb_in  (wb_stb_in),
      .wb_we_in   (wb_we_in),
      .wb_adr_in  (wb_adr_in),
      .wb_dat_in  (wb_dat_in),
      .wb_sel_in  (wb_sel_in),
      .wb_dat_out (wb_dat_out),
      .wb_ack_out (wb_ack_out),
      .req_out    (req),
      .rdata_in   (rdata)
   );

   // ---------------------------------------------------------------
   // link quality estimator
   // ---------------------------------------------------------------
   logic [6:0] lqi_value;
   logic       lqi_done;

   radio_lqi_estimator #(
      .SYMBOLS (SYMBOLS),
      .ERR_W   (radio_regs_pkg::LQI_ERR_W)
   ) u_lqi (
      .ref_clk_in             (ref_clk_in),
      .reset_n_in             (reset_n_in),
      .sync_found_in          (sync_found_in),
      .symbol_valid_in        (symbol_valid_in),
      .symbol_error_in        (symbol_error_in),
      .link_quality_value_out (lqi_value),
      .estimate_done_out      (lqi_done)
   );

   // ---------------------------------------------------------------
   // write decode
   // ---------------------------------------------------------------
   logic wr_coarse;
   logic wr_synth;
   logic wr_test_c;
   logic wr_test_b;
   logic wr_test_a;
   logic wr_power;

   // read-only indices have no strobe, so writes there fall away
   always_comb begin
      wr_coarse = 1'b0;
      wr_synth  = 1'b0;
      wr_test_c = 1'b0;
      wr_test_b = 1'b0;
      wr_test_a = 1'b0;
      wr_power  = 1'b0;
      if (!req.wr) begin
         wr_coarse = 1'b0;
      end else if (req.idx == radio_regs_pkg::IDX_COARSE_TUNE_CAL) begin
         wr_coarse = 1'b1;
      end else if (req.idx == radio_regs_pkg::IDX_SYNTH_CAL_CONTROL) begin
         wr_synth = 1'b1;
      end else if (req.idx == radio_regs_pkg::IDX_TEST_SETTING_C) begin
         wr_test_c = 1'b1;
      end else if (req.idx == radio_regs_pkg::IDX_TEST_SETTING_B) begin
         wr_test_b = 1'b1;
      end else if (req.idx == radio_regs_pkg::IDX_TEST_SETTING_A) begin
         wr_test_a = 1'b1;
      end else if (req.idx == radio_regs_pkg::IDX_AMP_POWER_LEVEL) begin
         wr_power = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   logic [7:0] coarse_tune_cal;
   logic [7:0] synth_cal_control;
   logic [7:0] test_setting_c;
   logic [7:0] test_setting_b;
   logic [7:0] test_setting_a;
   logic [7:0] amp_power_level;
   logic [7:0] next_coarse_tune_cal;
   logic [7:0] next_synth_cal_control;
   logic [7:0] next_test_setting_c;
   logic [7:0] next_test_setting_b;
   logic [7:0] next_test_setting_a;
   logic [7:0] next_amp_power_level;

   always_comb begin
      next_coarse_tune_cal   = coarse_tune_cal;
      next_synth_cal_control = synth_cal_control;
      next_test_setting_c    = test_setting_c;
      next_test_setting_b    = test_setting_b;
      next_test_setting_a    = test_setting_a;
      next_amp_power_level   = amp_power_level;
      // wake restore beats a fresh result, which beats a software write
      if (deep_sleep_wake_in) begin
         next_coarse_tune_cal = radio_regs_pkg::RST_COARSE_TUNE_CAL;
      end else if (cal_result_valid_in) begin
         next_coarse_tune_cal = {2'b00, cal_coarse_tune_in};
      end else if (wr_coarse) begin
         // saved per-channel value written back before a hop
         next_coarse_tune_cal = req.wdata & radio_regs_pkg::MASK_COARSE_TUNE;
      end
      if (wr_synth) begin
         next_synth_cal_control = req.wdata & radio_regs_pkg::MASK_SYNTH_CAL;
      end
      if (wr_test_c) begin
         next_test_setting_c = req.wdata;
      end
      if (wr_test_b) begin
         next_test_setting_b = req.wdata;
      end
      if (wr_test_a) begin
         next_test_setting_a = req.wdata;
      end
      if (wr_power) begin
         next_amp_power_level = req.wdata;
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         coarse_tune_cal   <= radio_regs_pkg::RST_COARSE_TUNE_CAL;
         synth_cal_control <= radio_regs_pkg::RST_SYNTH_CAL_CONTROL;
         test_setting_c    <= radio_regs_pkg::RST_TEST_SETTING_C;
         test_setting_b    <= radio_regs_pkg::RST_TEST_SETTING_B;
         test_setting_a    <= radio_regs_pkg::RST_TEST_SETTING_A;
         amp_power_level   <= radio_regs_pkg::RST_AMP_POWER_LEVEL;
      end else begin
         coarse_tune_cal   <= next_coarse_tune_cal;
         synth_cal_control <= next_synth_cal_control;
         test_setting_c    <= next_test_setting_c;
         test_setting_b    <= next_test_setting_b;
         test_setting_a    <= next_test_setting_a;
         amp_power_level   <= next_amp_power_level;
      end
   end

   // ---------------------------------------------------------------
   // demodulator status
   // ---------------------------------------------------------------
   logic [7:0] offset_estimate;
   logic [6:0] link_quality;
   logic       crc_match;
   logic [7:0] next_offset_estimate;
   logic [6:0] next_link_quality;
   logic       next_crc_match;
   logic       crc_flag;

   always_comb begin
      next_offset_estimate = offset_estimate;
      next_link_quality    = link_quality;
      next_crc_match       = crc_match;
      if (demod_event_in.offset_valid) begin
         // signed, one step is the reference frequency over 2^14
         next_offset_estimate = demod_event_in.offset_estimate_value;
      end
      if (lqi_done) begin
         next_link_quality = lqi_value;
      end
      // a comparison landing with an rx restart still counts
      if (demod_event_in.crc_done) begin
         next_crc_match = demod_event_in.crc_match;
      end else if (demod_event_in.rx_enter) begin
         next_crc_match = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         offset_estimate <= radio_regs_pkg::RST_OFFSET_ESTIMATE;
         link_quality    <= radio_regs_pkg::RST_LINK_QUALITY;
         crc_match       <= 1'b0;
      end else begin
         offset_estimate <= next_offset_estimate;
         link_quality    <= next_link_quality;
         crc_match       <= next_crc_match;
      end
   end

   // checking disabled reads as a match regardless of history
   assign crc_flag = crc_match | ~crc_check_enable_in;
   // the flag only carries meaning in legacy packet mode
   assign crc_match_valid_out = legacy_packet_compat_enable_in;

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   // unmapped indices read zero by default, unused bits read zero through the masks
   always_comb begin
      rdata = 8'h00;
      if (req.idx == radio_regs_pkg::IDX_COARSE_TUNE_CAL) begin
         rdata = coarse_tune_cal & radio_regs_pkg::MASK_COARSE_TUNE;
      end else if (req.idx == radio_regs_pkg::IDX_SYNTH_CAL_CONTROL) begin
         rdata = synth_cal_control & radio_regs_pkg::MASK_SYNTH_CAL;
      end else if (req.idx == radio_regs_pkg::IDX_TEST_SETTING_C) begin
         rdata = test_setting_c;
      end else if (req.idx == radio_regs_pkg::IDX_TEST_SETTING_B) begin
         rdata = test_setting_b;
      end else if (req.idx == radio_regs_pkg::IDX_TEST_SETTING_A) begin
         rdata = test_setting_a;
      end else if (req.idx == radio_regs_pkg::IDX_AMP_POWER_LEVEL) begin
         rdata = amp_power_level;
      end else if (req.idx == radio_regs_pkg::IDX_CHIP_ID_HIGH) begin
         rdata = PART_ID;
      end else if (req.idx == radio_regs_pkg::IDX_CHIP_ID_LOW) begin
         rdata = REV_ID;
      end else if (req.idx == radio_regs_pkg::IDX_CARRIER_OFFSET_ESTIMATE) begin
         rdata = offset_estimate;
      end else if (req.idx == radio_regs_pkg::IDX_LINK_QUALITY_STATUS) begin
         rdata = {crc_flag, link_quality};
      end
   end

   // ---------------------------------------------------------------
   // outputs to the radio core
   // ---------------------------------------------------------------
   assign osc_select_cal_enable_out =
      test_setting_a[radio_regs_pkg::OSC_SELECT_CAL_BIT];
   // stage request from the calibrator is gated by the enable bit
   assign osc_select_stage_run_out =
      osc_select_stage_req_in & osc_select_cal_enable_out;

   always_comb begin
      radio_config_out.coarse_tune_value = coarse_tune_cal[5:0];
      radio_config_out.synth_cal_control = synth_cal_control[6:0];
      radio_config_out.test_setting_c    = test_setting_c;
      radio_config_out.test_setting_b    = test_setting_b;
      radio_config_out.test_setting_a    = test_setting_a;
      radio_config_out.amp_power_level   = amp_power_level;
   end

endmodule

// File: radio_calib_status_regs_assertions.sv
// port-level assertion checker for the radio register bank
`timescale 1ns/10ps
module radio_calib_status_regs_assertions (
   input wire logic                                   ref_clk_in,
   input wire logic                                   reset_n_in,
   input wire logic                                   wb_cyc_in,
   input wire logic                                   wb_stb_in,
   input wire logic                                   wb_we_in,
   input wire logic [radio_regs_pkg::WB_ADDR_W-1:0]   wb_adr_in,
   input wire logic [radio_regs_pkg::WB_DATA_W-1:0]   wb_dat_in,
   input wire logic [3:0]                             wb_sel_in,
   input wire logic [radio_regs_pkg::WB_DATA_W-1:0]   wb_dat_out,
   input wire logic                                   wb_ack_out,
   input wire logic                                   deep_sleep_wake_in,
   input wire logic                                   osc_select_stage_req_in,
   input wire logic                                   osc_select_stage_run_out,
   input wire logic                                   osc_select_cal_enable_out,
   input wire logic                                   legacy_packet_compat_enable_in,
   input wire logic                                   crc_match_valid_out,
   input wire radio_regs_pkg::radio_config_t          radio_config_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_take;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   sequence s_wr(idx);
      s_take ##0 (wb_we_in && wb_sel_in[0] && wb_adr_in[17:2] == idx);
   endsequence
   property p_ack; s_take |=> wb_ack_out ##1 !wb_ack_out; endproperty
   property p_no_req; !(wb_cyc_in && wb_stb_in) |=> !wb_ack_out; endproperty
   property p_hi_zero; wb_ack_out |-> wb_dat_out[31:8] == 24'h0; endproperty
   property p_power;
      s_wr(16'hDF2E) |=> radio_config_out.amp_power_level == $past(wb_dat_in[7:0]);
   endproperty
   property p_synth;
      s_wr(16'hDF1F) |=> radio_config_out.synth_cal_control == $past(wb_dat_in[6:0]);
   endproperty
   property p_wake; deep_sleep_wake_in |=> radio_config_out.coarse_tune_value == 6'h20; endproperty
   property p_osc_run;
      osc_select_stage_run_out == (osc_select_stage_req_in && osc_select_cal_enable_out);
   endproperty
   property p_osc_en; osc_select_cal_enable_out == radio_config_out.test_setting_a[1]; endproperty
   property p_compat; crc_match_valid_out == legacy_packet_compat_enable_in; endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
   a_no_req: assert property (p_no_req) else $error("ack without request");
   a_hi_zero: assert property (p_hi_zero) else $error("unused read bits not zero");
   a_power: assert property (p_power) else $error("power level write lost");
   a_synth: assert property (p_synth) else $error("synth control write lost");
   a_wake: assert property (p_wake) else $error("coarse tune not restored on wake");
   a_osc_run: assert property (p_osc_run) else $error("osc select stage gating wrong");
   a_osc_en: assert property (p_osc_en) else $error("osc select enable not bit one");
   a_compat: assert property (p_compat) else $error("crc valid flag wrong");
endmodule

// File: test_radio_calib_status_regs.sv
// self-checking bench for the radio calibration and status register bank
`timescale 1ns/10ps
module test_radio_calib_status_regs;
   localparam logic [7:0] PART = 8'h5A; // arbitrary identification value
   localparam logic [7:0] REV  = 8'h01; // arbitrary identification value
   logic ref_clk_in = 0, reset_n_in = 0, cyc = 0, we = 0, wake = 0, calv = 0;
   logic oreq = 0, crc_en = 1, compat = 0, sync = 0, symv = 0;
   logic [17:0] adr = 0;
   logic [31:0] dat = 0, q, r = 32'hED0C;
   logic [3:0]  sel = 0, serr = 0;
   logic [5:0]  cal_ct = 0;
   logic [31:0] dat_o;
   logic        ack, orun, oen, cvalid;
   radio_regs_pkg::demod_event_t  dev = '0;
   radio_regs_pkg::radio_config_t cfg;
   int num_errors = 0, check_count = 0, s = 0, k;
   logic [15:0] ridx [10] = '{16'hDF1E, 16'hDF1F, 16'hDF23, 16'hDF24, 16'hDF25, 16'hDF2E,
                              16'hDF36, 16'hDF37, 16'hDF38, 16'hDF39};
   logic [7:0]  rmsk [10] = '{8'h3F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 0, 0, 0, 0};
   logic [7:0]  mdl [10] = '{8'h20, 8'h0D, 8'h88, 8'h11, 8'h0B, 8'h00, PART, REV, 0, 0};
   logic [11:0] cev [4] = '{12'h600, 12'h800, 12'hE00, 12'h400};
   logic        cbit [4] = '{1, 0, 1, 0};
   // ---------------------------------------------------------------
   // design, clock and helpers
   // ---------------------------------------------------------------
   radio_calib_status_regs #(.PART_ID(PART), .REV_ID(REV), .SYMBOLS(8)) DUT (
      .ref_clk_in, .reset_n_in, .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
      .wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(sel), .wb_dat_out(dat_o), .wb_ack_out(ack),
      .deep_sleep_wake_in(wake), .cal_result_valid_in(calv), .cal_coarse_tune_in(cal_ct),
      .osc_select_stage_req_in(oreq), .osc_select_stage_run_out(orun),
      .osc_select_cal_enable_out(oen), .demod_event_in(dev), .crc_check_enable_in(crc_en),
      .legacy_packet_compat_enable_in(compat), .sync_found_in(sync), .symbol_valid_in(symv),
      .symbol_error_in(serr), .crc_match_valid_out(cvalid), .radio_config_out(cfg));
   always #4 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      oreq <= ~oreq;
      compat <= r[5];
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      repeat (8) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
      return x;
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      if (num_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // low address bits and sel come from the data so they vary with it
   task automatic wb(input logic w, input logic [15:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1;
      we <= w;
      adr <= {idx, d[9:8]};
      dat <= d;
      sel <= d[3:0];
      @(posedge ref_clk_in);
      while (ack !== 1'b1 && n < 50) begin
         @(posedge ref_clk_in);
         n++;
      end
      if (n == 50) begin
         num_errors++;
         report_and_stop;
      end
      q = dat_o;
      cyc <= 0;
      @(posedge ref_clk_in);
   endtask
   task automatic rd(input int i);
      wb(0, ridx[i], 0);
      check(q, mdl[i]);
   endtask
   task automatic wrm(input int i, input logic [31:0] d);
      wb(1, ridx[i], d);
      if (d[0])
         mdl[i] = (mdl[i] & ~rmsk[i]) | (d[7:0] & rmsk[i]);
      rd(i);
   endtask
   task automatic step(input logic w, input logic c, input logic [11:0] e);
      wake <= w;
      calv <= c;
      dev <= e;
      @(posedge ref_clk_in);
      wake <= 0;
      calv <= 0;
      dev <= '0;
      @(posedge ref_clk_in);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge ref_clk_in);
      reset_n_in <= 1;
      @(posedge ref_clk_in);
      for (k = 0; k < 10; k++)
         rd(k);
      for (k = 0; k < 30; k++) begin
         r = lfsr(r);
         wrm(k % 10, r);
      end
      check(cfg, {mdl[0][5:0], mdl[1][6:0], mdl[2], mdl[3], mdl[4], mdl[5]});
      wb(1, 16'hDF20, 32'hFF);
      wb(0, 16'hDF20, 0);
      check(q, 0);
      wrm(3, 32'h31);
      wrm(3, 32'h35);
      wrm(4, 32'h09);
      check({oen, orun}, 0);
      wrm(4, 32'h0B);
      check({oen, orun, cvalid}, {1'b1, oreq, compat});
      wrm(0, 32'h15);
      step(1, 0, 0);
      mdl[0] = 8'h20;
      rd(0);
      cal_ct <= r[5:0];
      step(0, 1, 0);
      mdl[0] = {2'b00, r[5:0]};
      rd(0);
      for (k = 0; k < 4; k++) begin
         step(0, 0, cev[k]);
         mdl[9][7] = cbit[k];
         rd(9);
      end
      crc_en <= 0;
      wb(0, ridx[9], 0);
      check(q, 8'h80);
      crc_en <= 1;
      for (k = 0; k < 3; k++) begin
         r = lfsr(r);
         step(0, 0, {4'h1, r[7:0]});
         mdl[8] = r[7:0];
         rd(8);
      end
      // second sync after three symbols must restart the count
      for (k = 0; k < 13; k++) begin
         r = lfsr(r);
         sync <= (k == 0 || k == 4);
         symv <= !(k == 0 || k == 4);
         serr <= r[3:0];
         s = (k == 0 || k == 4) ? 0 : s + r[3:0];
         @(posedge ref_clk_in);
      end
      sync <= 0;
      symv <= 0;
      repeat (3) @(posedge ref_clk_in);
      // eight symbols of four bits fit seven bits, so no low bits drop
      mdl[9][6:0] = 7'(s);
      rd(9);
      report_and_stop;
   end
   initial begin
      #100000;
      num_errors++;
      report_and_stop;
   end
endmodule
bind radio_calib_status_regs radio_calib_status_regs_assertions chk (
   .ref_clk_in, .reset_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_in,
   .wb_sel_in, .wb_dat_out, .wb_ack_out, .deep_sleep_wake_in, .osc_select_stage_req_in,
   .osc_select_stage_run_out, .osc_select_cal_enable_out, .legacy_packet_compat_enable_in,
   .crc_match_valid_out, .radio_config_out);
